// file: core/wiper_pot_slave.sv
// Two-wire slave with wiper register and non-volatile store
`timescale 1ns/1ps
`include "wiper_pot_cfg.svh"
module wiper_pot_slave #(
    parameter int   NV_PROG_CYCLES = `NV_PROG_CYCLES,
    parameter logic [7:0] DEVICE_ID = 8'h5a // Arbitrary value
) (
    input  wire logic         clock_i,
    input  wire logic         rst_i,
    input  wire logic         link_clk_i,
    input  wire logic         scl_i,
    input  wire logic         sda_i,
    output logic              sda_o,
    output logic              sda_oe_o,
    input  wire logic         nv_ready_i,
    output logic [7:0]        wiper_o,
    output logic [255:0]      tap_sel_o,
    output logic              nv_busy_o
);
    // ------------------------------------------------------------
    // Link inputs
    // ------------------------------------------------------------
    wiper_pot_pkg::link_in_t sin;
    wiper_pot_pkg::link_in_t sout;
    wiper_pot_pkg::link_state_t state_q;

    logic       ack_tgl;
    logic       prog_tgl_q;
    logic       link_rst;
    logic       scl_q;
    logic       sda_q;
    logic       start_w;
    logic       stop_w;
    logic       rise_w;
    logic       fall_w;
    logic       busy_w;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    logic [7:0] byte_w;
    logic [7:0] ptr_q;
    logic [7:0] rd_w;
    logic       ack_w;
    logic       ack_q;
    logic       rw_q;
    logic       mack_q;
    logic       byte_end_w;
    logic       we_w;
    logic       vsel_q;
    logic       recalled_q;
    logic       wrote_q;
    logic       nv_pend_q;
    logic [2:0] nv_idx_q;
    logic [7:0] nv_data_q;
    logic [7:0] mem_q [`NV_ENTRIES];

    assign sin = '{rst: rst_i, ready: nv_ready_i, ack: ack_tgl, scl: scl_i, sda: sda_i};

    sync_filter #(.W($bits(wiper_pot_pkg::link_in_t)), .STABLE(`FILT_SAMPLES)) u_in_sync (
        .clock_i (link_clk_i),
        .d_i     (sin),
        .q_o     (sout)
    );

    assign link_rst = sout.rst;

    // ------------------------------------------------------------
    // Programming timer on the system clock
    // ------------------------------------------------------------
    nv_prog_timer #(.CYCLES(NV_PROG_CYCLES)) u_timer (
        .clock_i   (clock_i),
        .rst_i     (rst_i),
        .req_tgl_i (prog_tgl_q),
        .busy_o    (nv_busy_o),
        .ack_tgl_o (ack_tgl)
    );

    // Busy from the stop until the timer's answer returns
    assign busy_w = prog_tgl_q != sout.ack;

    // ------------------------------------------------------------
    // Bus conditions
    // ------------------------------------------------------------
    always_ff @(posedge link_clk_i) begin
        if (link_rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= sout.scl;
            sda_q <= sout.sda;
        end
    end

    assign start_w = sout.scl & scl_q & sda_q & ~sout.sda;
    assign stop_w  = sout.scl & scl_q & ~sda_q & sout.sda;
    assign rise_w  = sout.scl & ~scl_q;
    assign fall_w  = ~sout.scl & scl_q;
    assign byte_w  = {sh_q[6:0], sout.sda};
    assign byte_end_w = rise_w && cnt_q == 4'd7;
    assign we_w    = state_q == wiper_pot_pkg::ST_WDATA && byte_end_w && !nv_pend_q;

    // ------------------------------------------------------------
    // Acknowledge decision for a received byte
    // ------------------------------------------------------------
    always_comb begin
        ack_w = 1'b0;
        case (state_q)
            wiper_pot_pkg::ST_DEV: begin
                ack_w = byte_w[7:1] == `DEV_ADDR;
            end
            wiper_pot_pkg::ST_REG: begin
                ack_w = byte_w <= `ADDR_ACCESS_CTL && byte_w != `ADDR_RSVD;
            end
            wiper_pot_pkg::ST_WDATA: begin
                ack_w = !nv_pend_q && ptr_q <= `ADDR_ACCESS_CTL && ptr_q != `ADDR_RSVD;
                if (ptr_q == `ADDR_ACCESS_CTL && byte_w[6:0] != 7'h00) begin
                    ack_w = 1'b0;
                end
            end
            default: begin
                ack_w = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb begin
        rd_w = `RSVD_DATA;
        if (ptr_q == `ADDR_STORE) begin
            rd_w = vsel_q ? wiper_o : mem_q[0];
        end else if (ptr_q == `ADDR_ID) begin
            rd_w = DEVICE_ID;
        end else if (ptr_q >= `ADDR_GP_LO && ptr_q <= `ADDR_GP_HI) begin
            rd_w = mem_q[3'(ptr_q[2:0] - 3'd1)];
        end else if (ptr_q == `ADDR_ACCESS_CTL) begin
            rd_w = {vsel_q, 7'h00};
        end
    end

    // ------------------------------------------------------------
    // Protocol state machine
    // ------------------------------------------------------------
    always_ff @(posedge link_clk_i) begin
        if (link_rst) begin
            state_q  <= wiper_pot_pkg::ST_IDLE;
            cnt_q    <= 4'h0;
            sh_q     <= 8'h00;
            ptr_q    <= 8'h00;
            ack_q    <= 1'b0;
            rw_q     <= 1'b0;
            mack_q   <= 1'b0;
            sda_oe_o <= 1'b0;
        end else if (stop_w) begin
            state_q  <= wiper_pot_pkg::ST_IDLE;
            sda_oe_o <= 1'b0;
        end else if (start_w) begin
            cnt_q    <= 4'h0;
            sda_oe_o <= 1'b0;
            if (!busy_w && recalled_q && !wrote_q) begin
                state_q <= wiper_pot_pkg::ST_DEV;
            end else begin
                state_q <= wiper_pot_pkg::ST_IDLE;
            end
        end else begin
            case (state_q)
                wiper_pot_pkg::ST_DEV, wiper_pot_pkg::ST_REG, wiper_pot_pkg::ST_WDATA: begin
                    if (rise_w) begin
                        sh_q  <= byte_w;
                        cnt_q <= cnt_q + 4'd1;
                        if (cnt_q == 4'd7) begin
                            ack_q <= ack_w;
                            if (state_q == wiper_pot_pkg::ST_DEV) begin
                                rw_q <= byte_w[0];
                            end
                            if (state_q == wiper_pot_pkg::ST_REG && ack_w) begin
                                ptr_q <= byte_w;
                            end
                        end
                    end else if (fall_w && cnt_q == 4'd8) begin
                        cnt_q <= 4'h0;
                        if (ack_q) begin
                            sda_oe_o <= 1'b1;
                            if (state_q == wiper_pot_pkg::ST_DEV) begin
                                state_q <= wiper_pot_pkg::ST_DEV_ACK;
                            end else if (state_q == wiper_pot_pkg::ST_REG) begin
                                state_q <= wiper_pot_pkg::ST_REG_ACK;
                            end else begin
                                state_q <= wiper_pot_pkg::ST_WACK;
                            end
                        end else begin
                            state_q <= wiper_pot_pkg::ST_WAIT;
                        end
                    end
                end
                wiper_pot_pkg::ST_DEV_ACK: begin
                    if (fall_w) begin
                        if (rw_q) begin
                            sh_q     <= rd_w;
                            sda_oe_o <= ~rd_w[7];
                            state_q  <= wiper_pot_pkg::ST_RDATA;
                        end else begin
                            sda_oe_o <= 1'b0;
                            state_q  <= wiper_pot_pkg::ST_REG;
                        end
                    end
                end
                wiper_pot_pkg::ST_REG_ACK: begin
                    if (fall_w) begin
                        sda_oe_o <= 1'b0;
                        state_q  <= wiper_pot_pkg::ST_WDATA;
                    end
                end
                wiper_pot_pkg::ST_WACK: begin
                    if (fall_w) begin
                        sda_oe_o <= 1'b0;
                        ptr_q    <= ptr_q + 8'd1;
                        state_q  <= wiper_pot_pkg::ST_WDATA;
                    end
                end
                wiper_pot_pkg::ST_RDATA: begin
                    if (fall_w) begin
                        if (cnt_q == 4'd7) begin
                            sda_oe_o <= 1'b0;
                            cnt_q    <= 4'h0;
                            state_q  <= wiper_pot_pkg::ST_RACK;
                        end else begin
                            sda_oe_o <= ~sh_q[6];
                            sh_q     <= {sh_q[6:0], 1'b0};
                            cnt_q    <= cnt_q + 4'd1;
                        end
                    end
                end
                wiper_pot_pkg::ST_RACK: begin
                    if (rise_w) begin
                        mack_q <= ~sout.sda;
                        if (sout.sda) begin
                            state_q <= wiper_pot_pkg::ST_WAIT;
                        end else begin
                            ptr_q <= ptr_q + 8'd1;
                        end
                    end else if (fall_w && mack_q) begin
                        sh_q     <= rd_w;
                        sda_oe_o <= ~rd_w[7];
                        state_q  <= wiper_pot_pkg::ST_RDATA;
                    end
                end
                wiper_pot_pkg::ST_IDLE, wiper_pot_pkg::ST_WAIT: begin
                    sda_oe_o <= 1'b0;
                end
                default: begin
                    state_q  <= wiper_pot_pkg::ST_IDLE;
                    sda_oe_o <= 1'b0;
                end
            endcase
        end
    end

    // Open-drain: only ever pulls low
    always_ff @(posedge link_clk_i) begin
        sda_o <= 1'b0;
    end

    // ------------------------------------------------------------
    // Register writes and recall
    // ------------------------------------------------------------
    always_ff @(posedge link_clk_i) begin
        if (link_rst) begin
            wiper_o    <= `WIPER_RESET;
            vsel_q     <= 1'b0;
            recalled_q <= 1'b0;
        end else if (!recalled_q) begin
            if (sout.ready) begin
                wiper_o    <= mem_q[0];
                recalled_q <= 1'b1;
            end
        end else if (we_w) begin
            if (ptr_q == `ADDR_STORE) begin
                wiper_o <= byte_w;
            end
            if (ptr_q == `ADDR_ACCESS_CTL) begin
                vsel_q <= byte_w[`VSEL_BIT];
            end
        end
    end

    always_ff @(posedge link_clk_i) begin
        if (link_rst) begin
            nv_pend_q  <= 1'b0;
            nv_idx_q   <= 3'h0;
            nv_data_q  <= 8'h00;
            wrote_q    <= 1'b0;
            prog_tgl_q <= 1'b0;
        end else if (stop_w) begin
            wrote_q   <= 1'b0;
            nv_pend_q <= 1'b0;
            if (nv_pend_q) begin
                prog_tgl_q <= ~prog_tgl_q;
            end
        end else if (start_w) begin
            nv_pend_q <= 1'b0;
        end else if (we_w) begin
            wrote_q <= 1'b1;
            if (ptr_q == `ADDR_STORE && !vsel_q) begin
                nv_pend_q <= 1'b1;
                nv_idx_q  <= 3'h0;
                nv_data_q <= byte_w;
            end else if (ptr_q >= `ADDR_GP_LO && ptr_q <= `ADDR_GP_HI) begin
                nv_pend_q <= 1'b1;
                nv_idx_q  <= 3'(ptr_q[2:0] - 3'd1);
                nv_data_q <= byte_w;
            end
        end
    end

    // ------------------------------------------------------------
    // Non-volatile entries, committed at the stop
    // ------------------------------------------------------------
    for (genvar i = 0; i < `NV_ENTRIES; i++) begin : g_nv
        always_ff @(posedge link_clk_i) begin
            if (link_rst) begin
                mem_q[i] <= (i == 0) ? `STORE_RESET : `GP_RESET;
            end else if (stop_w && nv_pend_q && nv_idx_q == 3'(i)) begin
                mem_q[i] <= nv_data_q;
            end
        end
    end

    // ------------------------------------------------------------
    // One-hot tap select
    // ------------------------------------------------------------
    always_ff @(posedge link_clk_i) begin
        if (link_rst) begin
            tap_sel_o <= 256'h1 << `WIPER_RESET;
        end else begin
            tap_sel_o <= 256'h1 << wiper_o;
        end
    end

endmodule : wiper_pot_slave

// file: shared/wiper_pot_cfg.svh
// Constants of the serial wiper potentiometer slave
// Operation
// - At reset the wiper register takes midscale before any recall.
// - Once supply is ready, copy the stored initial value into the wiper.
// - Exactly one tap is selected, chosen by the 8-bit wiper value.
// - Five 8-bit general non-volatile registers, readable and writable over the bus.
// - Start is data falling while clock high; nothing answered before a start.
// - Stop is data rising while clock high; master ends operations with it.
// - Fixed 7-bit address 0101000; last bit of first byte is read when 1.
// - Acknowledge the address byte only when it matches our address.
// - The receiver of a byte drives data low on the ninth clock.
// - When addressed for write, acknowledge the memory address and every data byte (code nacks 07h, >08h, bytes after an NV write, 08h data with 6:0 set).
// - In read, send 8 bits, release for ninth, sample; on acknowledge continue.
// - No master acknowledge: stop sending and wait idle for a stop.
// - A stop ending a non-volatile write starts the programming cycle.
// - The programming cycle finishes within 10 ms; 4 ms typical.
// - Anything but a stop after the last data acknowledge cancels programming (code cancels only on a repeated start).
// - While programming, ignore every master request, our own address too.
// - Volatile writes commit on the last data bit, before the acknowledge.
// - After any write, accept no further command until a stop.
// - Withhold the address acknowledge while busy; master may poll by readdressing.
// - Address 00h reaches the wiper when volatile select is 1, else the store.
// - Writing the store also moves the wiper; writing the wiper leaves the store.
`ifndef WIPER_POT_CFG_SVH
`define WIPER_POT_CFG_SVH

`define DEV_ADDR        7'h28
`define WIPER_RESET     8'h80
`define STORE_RESET     8'h80
`define GP_RESET        8'h00
`define ADDR_STORE      8'h00
`define ADDR_ID         8'h01
`define ADDR_GP_LO      8'h02
`define ADDR_GP_HI      8'h06
`define ADDR_RSVD       8'h07
`define ADDR_ACCESS_CTL 8'h08
`define VSEL_BIT        7
`define RSVD_DATA       8'hff
`define NV_ENTRIES      6
`define FILT_SAMPLES    2
`define NV_PROG_TIME_MS 4
`define CLK_KHZ         100000
`define NV_PROG_CYCLES  (`NV_PROG_TIME_MS * `CLK_KHZ)

`endif

// file: shared/wiper_pot_pkg.sv
// Types shared by the serial wiper potentiometer slave
package wiper_pot_pkg;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'h0,
        ST_DEV     = 4'h1,
        ST_DEV_ACK = 4'h2,
        ST_REG     = 4'h3,
        ST_REG_ACK = 4'h4,
        ST_WDATA   = 4'h5,
        ST_WACK    = 4'h6,
        ST_RDATA   = 4'h7,
        ST_RACK    = 4'h8,
        ST_WAIT    = 4'h9
    } link_state_t;

    // Signals entering the link domain
    typedef struct packed {
        logic rst;
        logic ready;
        logic ack;
        logic scl;
        logic sda;
    } link_in_t;

endpackage : wiper_pot_pkg

// file: core/sync_filter.sv
// Two-stage synchroniser followed by a per-bit stability filter
`timescale 1ns/1ps
module sync_filter #(
    parameter int W      = 1,
    parameter int STABLE = 2
) (
    input  wire logic         clock_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;

    always_ff @(posedge clock_i) begin
        s1_q <= d_i;
        s2_q <= s1_q;
    end

    // A level passes only after STABLE equal samples
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic [STABLE-1:0] hist_q;
        logic              lvl_q;
        always_ff @(posedge clock_i) begin
            hist_q <= {hist_q[STABLE-2:0], s2_q[i]};
            if (&hist_q) begin
                lvl_q <= 1'b1;
            end else if (~|hist_q) begin
                lvl_q <= 1'b0;
            end
        end
        assign q_o[i] = lvl_q;
    end

endmodule : sync_filter

// file: core/nv_prog_timer.sv
// Non-volatile programming cycle timer on the system clock
`timescale 1ns/1ps
`include "wiper_pot_cfg.svh"
module nv_prog_timer #(
    parameter int CYCLES = `NV_PROG_CYCLES
) (
    input  wire logic clock_i,
    input  wire logic rst_i,
    input  wire logic req_tgl_i,
    output logic      busy_o,
    output logic      ack_tgl_o
);
    localparam int CW = $clog2(CYCLES + 1);

    logic          req_s;
    logic          seen_q;
    logic [CW-1:0] cnt_q;

    sync_filter #(.W(1), .STABLE(`FILT_SAMPLES)) u_req_sync (
        .clock_i (clock_i),
        .d_i     (req_tgl_i),
        .q_o     (req_s)
    );

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            busy_o    <= 1'b0;
            ack_tgl_o <= 1'b0;
            seen_q    <= 1'b0;
            cnt_q     <= '0;
        end else if (!busy_o) begin
            if (req_s != seen_q) begin
                busy_o <= 1'b1;
                seen_q <= req_s;
                cnt_q  <= '0;
            end
        end else if (cnt_q == CW'(CYCLES - 1)) begin
            busy_o    <= 1'b0;
            ack_tgl_o <= ~ack_tgl_o;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

endmodule : nv_prog_timer

// file: dv/wiper_pot_master.sv
// Behavioural two-wire bus master driving the slave's clock and data lines
`timescale 1ns/1ps
module wiper_pot_master #(
    parameter int Q = 64
) (
    input  wire logic clock_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic q_wait();
        repeat (Q) @(posedge clock_i);
    endtask : q_wait

    // Data only moves halfway into the low phase, never while clock is high
    task automatic bit_cycle(input logic low, output logic seen);
        q_wait();
        sda_low_o <= low;
        q_wait();
        scl_o <= 1'b1;
        q_wait();
        seen = sda_i;
        q_wait();
        scl_o <= 1'b0;
    endtask : bit_cycle

    // Eight bits MSB first, then the ninth clock; writing ff releases the line
    task automatic xfer(input logic [7:0] wr, input logic ack_low, output logic [7:0] rd, output logic acked);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(~wr[i], s);
            rd[i] = s;
        end
        bit_cycle(ack_low, s);
        acked = ~s;
    endtask : xfer

    task automatic start();
        q_wait();
        sda_low_o <= 1'b0;
        q_wait();
        scl_o <= 1'b1;
        q_wait();
        sda_low_o <= 1'b1;
        q_wait();
        scl_o <= 1'b0;
    endtask : start

    task automatic stop();
        q_wait();
        sda_low_o <= 1'b1;
        q_wait();
        scl_o <= 1'b1;
        q_wait();
        sda_low_o <= 1'b0;
        q_wait();
    endtask : stop
endmodule : wiper_pot_master

// file: dv/wiper_pot_slave_chk.sv
// Concurrent checks on the wiper potentiometer slave ports
`timescale 1ns/1ps
module wiper_pot_slave_chk #(
    parameter int NV_PROG_CYCLES = 400000
) (
    input wire logic         clock_i,
    input wire logic         rst_i,
    input wire logic         link_clk_i,
    input wire logic         scl_i,
    input wire logic         sda_i,
    input wire logic         sda_o,
    input wire logic         sda_oe_o,
    input wire logic         nv_ready_i,
    input wire logic [7:0]   wiper_o,
    input wire logic [255:0] tap_sel_o,
    input wire logic         nv_busy_o
);
    int busy_cnt_q;

    always_ff @(posedge clock_i) begin
        if (rst_i || !nv_busy_o) begin
            busy_cnt_q <= 0;
        end else begin
            busy_cnt_q <= busy_cnt_q + 1;
        end
    end

    a_tap_follow: assert property (@(posedge link_clk_i) disable iff (rst_i)
        tap_sel_o == (256'h1 << $past(wiper_o))) else $error("tap select does not match wiper");
    a_od_low: assert property (@(posedge link_clk_i) disable iff (rst_i)
        sda_oe_o |-> !sda_o) else $error("data driven high");
    a_oe_scl_low: assert property (@(posedge link_clk_i) disable iff (rst_i)
        $changed(sda_oe_o) |-> !scl_i) else $error("data output moved while clock high");
    a_wiper_scl_high: assert property (@(posedge link_clk_i) disable iff (rst_i)
        $changed(wiper_o) |-> scl_i) else $error("wiper moved outside last data bit");
    a_busy_no_ack: assert property (@(posedge clock_i) disable iff (rst_i)
        nv_busy_o |-> !sda_oe_o) else $error("answer given while programming");
    a_busy_at_stop: assert property (@(posedge clock_i) disable iff (rst_i)
        $rose(nv_busy_o) |-> scl_i && sda_i) else $error("programming began without stop");
    a_busy_len: assert property (@(posedge clock_i) disable iff (rst_i)
        $fell(nv_busy_o) |-> (busy_cnt_q + 1 >= NV_PROG_CYCLES) && (busy_cnt_q <= NV_PROG_CYCLES + 1))
        else $error("programming cycle length wrong");
    a_busy_quiet: assert property (@(posedge clock_i) disable iff (rst_i)
        nv_busy_o && $past(nv_busy_o) |-> $stable(wiper_o)) else $error("wiper moved while programming");
endmodule : wiper_pot_slave_chk

bind wiper_pot_slave wiper_pot_slave_chk #(
    .NV_PROG_CYCLES(NV_PROG_CYCLES)
) wiper_pot_slave_chk_i (
    .clock_i    (clock_i),
    .rst_i      (rst_i),
    .link_clk_i (link_clk_i),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .sda_o      (sda_o),
    .sda_oe_o   (sda_oe_o),
    .nv_ready_i (nv_ready_i),
    .wiper_o    (wiper_o),
    .tap_sel_o  (tap_sel_o),
    .nv_busy_o  (nv_busy_o)
);

// file: dv/wiper_pot_slave_bench.sv
// Self-checking bench for the wiper potentiometer slave
`timescale 1ns/1ps
module wiper_pot_slave_bench;
    logic         clock_i;
    logic         link_clk_i;
    logic         rst_i;
    logic         nv_ready_i;
    logic         scl;
    logic         sda_low;
    logic         sda_o;
    logic         sda_oe_o;
    logic [7:0]   wiper_o;
    logic [255:0] tap_sel_o;
    logic         nv_busy_o;
    wire          sda_line;
    int           mismatches;
    int           n_checks;
    int           cycles;

    // Open-drain wire with pull-up
    assign sda_line = (sda_oe_o || sda_low) ? 1'b0 : 1'b1;

    wiper_pot_slave #(
        .NV_PROG_CYCLES (4000),
        .DEVICE_ID      (8'h5a)
    ) wiper_pot_slave_i (
        .clock_i    (clock_i),
        .rst_i      (rst_i),
        .link_clk_i (link_clk_i),
        .scl_i      (scl),
        .sda_i      (sda_line),
        .sda_o      (sda_o),
        .sda_oe_o   (sda_oe_o),
        .nv_ready_i (nv_ready_i),
        .wiper_o    (wiper_o),
        .tap_sel_o  (tap_sel_o),
        .nv_busy_o  (nv_busy_o)
    );

    wiper_pot_master wiper_pot_master_i (
        .clock_i   (clock_i),
        .sda_i     (sda_line),
        .scl_o     (scl),
        .sda_low_o (sda_low)
    );

    initial clock_i = 1'b0;
    always #5 clock_i = ~clock_i;
    initial begin
        link_clk_i = 1'b0;
        #3;
        forever #80 link_clk_i = ~link_clk_i;
    end

    task automatic check_bit(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit

    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check_byte

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    task automatic wr(input logic [7:0] d, output logic acked);
        logic [7:0] unused;
        wiper_pot_master_i.xfer(d, 1'b0, unused, acked);
    endtask : wr

    task automatic rd(input logic ack, output logic [7:0] d);
        logic unused;
        wiper_pot_master_i.xfer(8'hff, ack, d, unused);
    endtask : rd

    // Single register write: start, write address, register, data, stop
    task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
        logic a;
        wiper_pot_master_i.start();
        wr(8'h50, a);
        check_bit("ack_dev", 1'b1, a);
        wr(addr, a);
        check_bit("ack_reg", 1'b1, a);
        wr(data, a);
        check_bit("ack_data", 1'b1, a);
        wiper_pot_master_i.stop();
    endtask : wr_reg

    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 95000) begin
            mismatches++;
            close_out();
        end
    end

    initial begin
        logic       a;
        logic [7:0] d;
        rst_i      = 1'b1;
        nv_ready_i = 1'b0;
        repeat (160) @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (200) @(posedge clock_i);
        check_byte("wiper_reset", 8'h80, wiper_o);
        nv_ready_i <= 1'b1;
        repeat (300) @(posedge clock_i);
        check_byte("wiper_recall", 8'h80, wiper_o);
        check_bit("tap_mid", 1'b1, tap_sel_o[128]);
        wiper_pot_master_i.start();
        wr(8'h52, a);
        check_bit("ack_foreign", 1'b0, a);
        wiper_pot_master_i.stop();
        wr_reg(8'h08, 8'h80);
        wr_reg(8'h00, 8'h3c);
        check_byte("wiper_volatile", 8'h3c, wiper_o);
        check_bit("tap_volatile", 1'b1, tap_sel_o[8'h3c]);
        check_bit("busy_volatile", 1'b0, nv_busy_o);
        // General register write, then wait out its programming cycle
        wr_reg(8'h02, 8'h77);
        repeat (4200) @(posedge clock_i);
        // Sequential read through wiper, identity and first general register
        wiper_pot_master_i.start();
        wr(8'h50, a);
        wr(8'h00, a);
        wiper_pot_master_i.start();
        wr(8'h51, a);
        check_bit("ack_rd_dev", 1'b1, a);
        rd(1'b1, d);
        check_byte("rd_wiper", 8'h3c, d);
        rd(1'b1, d);
        check_byte("rd_ident", 8'h5a, d);
        rd(1'b0, d);
        check_byte("rd_gp", 8'h77, d);
        rd(1'b0, d);
        check_byte("rd_after_nack", 8'hff, d);
        wiper_pot_master_i.stop();
        // Stored value write, then poll through the programming cycle
        wr_reg(8'h08, 8'h00);
        wr_reg(8'h00, 8'ha5);
        check_byte("wiper_nv", 8'ha5, wiper_o);
        a = 1'b0;
        for (int i = 0; i < 4 && !a; i++) begin
            wiper_pot_master_i.start();
            wr(8'h50, a);
            if (i == 0) begin
                check_bit("poll_busy", 1'b0, a);
                check_bit("nv_busy", 1'b1, nv_busy_o);
            end
            if (!a) begin
                wiper_pot_master_i.stop();
            end
        end
        check_bit("poll_done", 1'b1, a);
        wr(8'h00, a);
        wiper_pot_master_i.start();
        wr(8'h51, a);
        rd(1'b0, d);
        check_byte("rd_store", 8'ha5, d);
        wiper_pot_master_i.stop();
        // General register write cut short by a repeated start
        wiper_pot_master_i.start();
        wr(8'h50, a);
        wr(8'h02, a);
        wr(8'h77, a);
        check_bit("ack_gp", 1'b1, a);
        wiper_pot_master_i.start();
        wr(8'h51, a);
        check_bit("ack_after_write", 1'b0, a);
        wiper_pot_master_i.stop();
        repeat (300) @(posedge clock_i);
        check_bit("busy_cancelled", 1'b0, nv_busy_o);
        close_out();
    end
endmodule : wiper_pot_slave_bench
